// [hdl/clkgen_defines.vh]
// constants for the clock mode generator
// assumes inclusion by hdl files sharing one 250 MHz clock
//
// Summary of operation
// - status reports mode in effect; equals request once conditions hold
// - status follows a request write only after several cycles
// - first control write with reference select zero locks it, amplifier off
// - self-clocked output ignores reference, which still feeds stable checks
// - external engaged output is oscillator over 2R until locked, then over R
// - fixed clock equals bus clock in external bypassed mode, and in external engaged when the case below does not hold
// - external engaged fixed clock is reference over 2 if PN/R>=4 and locked
// - fixed clock is off in internal engaged and self-clocked modes
// - high gain one selects high gain; valid only with reference select one
// - high gain bit accepts one write after reset
// - external engaged frequency is external times P times N over R
// - internal engaged frequency is internal reference / 7 * 64 * N / R
// - self-clocked is oscillator over R; bypassed is external over R
// - multiplier field decodes to N of 4 to 18 in steps of two
// - divider field decodes to R as a power of two, 1 to 128
// - multiplier or mode change clears lock without setting loss of lock flag
// - lost reference or oscillator in external engaged forces fallback mode
`ifndef CLKGEN_DEFINES_VH
`define CLKGEN_DEFINES_VH
// ****************************************************************
// mode encoding
// ****************************************************************
`define MODE_SELF     2'h0
`define MODE_INT_ENG  2'h1
`define MODE_EXT_BYP  2'h2
`define MODE_EXT_ENG  2'h3
// ****************************************************************
// reset values and timing
// ****************************************************************
`define MODE_RESET    2'h0
`define SETTLE_CYCLES 4'h4
`define PRESCALE_LOW  8'h40
`define PRESCALE_HIGH 8'h01
`define FIXED_MIN_RATIO 8'h04
`define IRG_DIVISOR   8'h07
`endif

// [hdl/clk_divider.v]
// divider that emits a one-cycle enable every div_val input enables
// assumes div_val is at least one and held steady between uses
module clk_divider #(
   parameter WIDTH = 9
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             in_en,
   input  wire [WIDTH-1:0] div_val,
   output reg              out_en
);
   reg [WIDTH-1:0] count_q;

   always @(posedge clk) begin
      if (rst) begin
         count_q <= {WIDTH{1'b0}};
         out_en  <= 1'b0;
      end else begin
         out_en <= 1'b0;
         if (in_en) begin
            if (count_q + {{(WIDTH-1){1'b0}}, 1'b1} >= div_val) begin
               count_q <= {WIDTH{1'b0}};
               out_en  <= 1'b1;
            end else begin
               count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// [hdl/fll_clock_mode_generator.v]
// clock generator mode control: mode request, actual mode, output enables
// assumes all clock sources arrive as one-cycle enables on clk
`include "clkgen_defines.vh"
module fll_clock_mode_generator (
   input  wire       clk,
   input  wire       rst,
   input  wire       ctrl_write,
   input  wire [1:0] mode_request_in,
   input  wire       reference_select_in,
   input  wire       range_in,
   input  wire       high_gain_in,
   input  wire       ctrl2_write,
   input  wire [2:0] multiplier_in,
   input  wire [2:0] divider_in,
   input  wire       oscillator_clock,
   input  wire       external_reference_clock,
   input  wire       bus_clock,
   input  wire       oscillator_stable_bit,
   input  wire       external_reference_status,
   input  wire       fll_lock_in,
   input  wire       ref_lost,
   input  wire       osc_lost,
   output reg  [1:0] mode_request_field,
   output reg  [1:0] actual_mode_status,
   output reg        reference_select,
   output reg        amp_enable,
   output reg        high_gain_select,
   output reg        range_q,
   output reg  [2:0] multiplier_field,
   output reg  [2:0] divider_field,
   output reg  [4:0] mult_n,
   output reg  [7:0] div_r,
   output reg  [7:0] prescale_p,
   output reg        lock_q,
   output reg        loss_of_lock_flag,
   output reg        generator_output_clock,
   output reg        fixed_frequency_clock,
   output reg        fixed_clock_on,
   output reg        ref_used_for_output
);
   // ****************************************************************
   // decode functions
   // ****************************************************************
   function [4:0] decode_n;
      input [2:0] f;
      begin
         decode_n = {1'b0, f, 1'b0} + 5'h04;
      end
   endfunction

   function [7:0] decode_r;
      input [2:0] f;
      begin
         decode_r = 8'h01 << f;
      end
   endfunction

   // ****************************************************************
   // control state
   // ****************************************************************
   reg        first_done_q;
   reg        hg_done_q;
   reg        ref_locked_q;
   reg        relock_q;
   reg        was_locked_q;
   reg [3:0]  settle_q;
   reg [1:0]  target_q;
   reg [1:0]  next_mode;
   reg [13:0] ratio;

   always @* begin
      next_mode = `MODE_SELF;
      case (target_q)
         `MODE_SELF:    next_mode = `MODE_SELF;
         `MODE_INT_ENG: next_mode = oscillator_stable_bit ?
                                    `MODE_INT_ENG : `MODE_SELF;
         `MODE_EXT_BYP: next_mode = external_reference_status ?
                                    `MODE_EXT_BYP : `MODE_SELF;
         `MODE_EXT_ENG: begin
            if (external_reference_status && oscillator_stable_bit)
               next_mode = `MODE_EXT_ENG;
            else if (external_reference_status)
               next_mode = `MODE_EXT_BYP;
            else
               next_mode = `MODE_SELF;
         end
         default: next_mode = `MODE_SELF;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         mode_request_field <= `MODE_RESET;
         actual_mode_status <= `MODE_RESET;
         target_q           <= `MODE_RESET;
         reference_select   <= 1'b0;
         amp_enable         <= 1'b0;
         high_gain_select   <= 1'b0;
         range_q            <= 1'b0;
         multiplier_field   <= 3'h0;
         divider_field      <= 3'h0;
         first_done_q       <= 1'b0;
         hg_done_q          <= 1'b0;
         ref_locked_q       <= 1'b0;
         relock_q           <= 1'b0;
         was_locked_q       <= 1'b0;
         settle_q           <= 4'h0;
         lock_q             <= 1'b0;
         loss_of_lock_flag  <= 1'b0;
      end else begin
         if (settle_q != 4'h0)
            settle_q <= settle_q - 4'h1;
         else
            actual_mode_status <= next_mode;
         lock_q <= fll_lock_in && (actual_mode_status == `MODE_EXT_ENG ||
                   actual_mode_status == `MODE_INT_ENG);
         if (lock_q && !fll_lock_in && !relock_q &&
             settle_q == 4'h0)
            loss_of_lock_flag <= 1'b1;
         if (lock_q)
            was_locked_q <= 1'b1;
         if (fll_lock_in)
            relock_q <= 1'b0;
         if (ctrl_write) begin
            mode_request_field <= mode_request_in;
            target_q           <= mode_request_in;
            settle_q           <= `SETTLE_CYCLES;
            range_q            <= range_in;
            first_done_q       <= 1'b1;
            if (!ref_locked_q) begin
               reference_select <= reference_select_in;
               amp_enable       <= reference_select_in;
               if (!first_done_q && !reference_select_in)
                  ref_locked_q <= 1'b1;
            end
            if (!hg_done_q) begin
               high_gain_select <= high_gain_in;
               hg_done_q        <= 1'b1;
            end
            if (mode_request_in != mode_request_field) begin
               lock_q   <= 1'b0;
               relock_q <= 1'b1;
               was_locked_q <= 1'b0;
            end
         end
         if (ctrl2_write) begin
            multiplier_field <= multiplier_in;
            divider_field    <= divider_in;
            settle_q         <= `SETTLE_CYCLES;
            if (multiplier_in != multiplier_field) begin
               lock_q   <= 1'b0;
               relock_q <= 1'b1;
               was_locked_q <= 1'b0;
            end
         end
         if (actual_mode_status == `MODE_EXT_ENG &&
             (ref_lost || osc_lost)) begin
            mode_request_field <= ref_lost ? `MODE_SELF : `MODE_EXT_BYP;
            target_q           <= ref_lost ? `MODE_SELF : `MODE_EXT_BYP;
            actual_mode_status <= ref_lost ? `MODE_SELF : `MODE_EXT_BYP;
            settle_q           <= 4'h0;
         end
      end
   end

   // ****************************************************************
   // output clock selection and division
   // ****************************************************************
   wire [8:0] out_div;
   wire       src_en;
   wire       out_en;
   wire       fixed_frequency_clock_en;

   // self and engaged modes run off the oscillator
   assign src_en  = (actual_mode_status == `MODE_EXT_BYP) ?
                    external_reference_clock : oscillator_clock;
   assign out_div = (actual_mode_status == `MODE_EXT_ENG && !was_locked_q) ?
                    {div_r, 1'b0} : {1'b0, div_r};

   clk_divider #(.WIDTH(9)) u_out_div (
      .clk     (clk),
      .rst     (rst),
      .in_en   (src_en),
      .div_val (out_div),
      .out_en  (out_en)
   );

   clk_divider #(.WIDTH(9)) u_fix_div (
      .clk     (clk),
      .rst     (rst),
      .in_en   (external_reference_clock),
      .div_val (9'h002),
      .out_en  (fixed_frequency_clock_en)
   );

   always @* begin
      // P times N, compared against R times the threshold
      ratio = {6'h00, prescale_p} * {9'h000, mult_n};
   end

   always @(posedge clk) begin
      if (rst) begin
         mult_n                 <= 5'h04;
         div_r                  <= 8'h01;
         prescale_p             <= `PRESCALE_LOW;
         generator_output_clock <= 1'b0;
         fixed_frequency_clock  <= 1'b0;
         fixed_clock_on         <= 1'b0;
         ref_used_for_output    <= 1'b0;
      end else begin
         mult_n     <= decode_n(multiplier_field);
         div_r      <= decode_r(divider_field);
         prescale_p <= range_q ? `PRESCALE_HIGH : `PRESCALE_LOW;
         generator_output_clock <= out_en;
         ref_used_for_output <= (actual_mode_status != `MODE_SELF) &&
                                (actual_mode_status != `MODE_INT_ENG);
         case (actual_mode_status)
            `MODE_SELF, `MODE_INT_ENG: begin
               fixed_clock_on        <= 1'b0;
               fixed_frequency_clock <= 1'b0;
            end
            `MODE_EXT_ENG: begin
               fixed_clock_on <= 1'b1;
               if (lock_q &&
                   ratio >= {6'h00, div_r} * {6'h00, `FIXED_MIN_RATIO})
                  fixed_frequency_clock <= fixed_frequency_clock_en;
               else
                  fixed_frequency_clock <= bus_clock;
            end
            default: begin
               fixed_clock_on        <= 1'b1;
               fixed_frequency_clock <= bus_clock;
            end
         endcase
      end
   end
endmodule

// [tb/clkgen_checker.sv]
// port assertions for the clock mode generator
// assumes one clk domain with synchronous active-high rst
module clkgen_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       ctrl_write,
   input wire logic       ctrl2_write,
   input wire logic       ref_lost,
   input wire logic       reference_select_in,
   input wire logic       bus_clock,
   input wire logic       reference_select,
   input wire logic       amp_enable,
   input wire logic       high_gain_select,
   input wire logic       range_q,
   input wire logic       lock_q,
   input wire logic       fixed_frequency_clock,
   input wire logic       fixed_clock_on,
   input wire logic [1:0] mode_request_field,
   input wire logic [1:0] actual_mode_status,
   input wire logic [2:0] multiplier_in,
   input wire logic [2:0] multiplier_field,
   input wire logic [2:0] divider_field,
   input wire logic [4:0] mult_n,
   input wire logic [7:0] div_r,
   input wire logic [7:0] prescale_p
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic wr_seen_q, ref_locked_q;
   // first control write after reset
   always @(posedge clk) begin
      if (rst) begin
         wr_seen_q    <= 1'h0;
         ref_locked_q <= 1'h0;
      end else if (ctrl_write && !wr_seen_q) begin
         wr_seen_q    <= 1'h1;
         ref_locked_q <= !reference_select_in;
      end
   end
   AST_MULT_N: assert property (
      mult_n == 5'h4 + {1'h0, $past(multiplier_field), 1'h0})
      else $error("multiplier decode wrong");
   AST_DIV_R: assert property (
      div_r == 8'h1 << $past(divider_field))
      else $error("divider decode wrong");
   AST_PRESCALE: assert property (
      prescale_p == ($past(range_q) ? 8'h01 : 8'h40))
      else $error("prescale wrong");
   AST_FIXED_OFF: assert property (
      !actual_mode_status[1] && !$past(actual_mode_status[1])
      |-> !fixed_clock_on && !fixed_frequency_clock)
      else $error("fixed clock on");
   AST_FIXED_BYP: assert property (
      actual_mode_status == 2'h2 && $past(actual_mode_status) == 2'h2
      |-> fixed_frequency_clock == $past(bus_clock))
      else $error("fixed not bus");
   AST_SETTLE: assert property (
      ctrl_write |=> ##1 $stable(actual_mode_status) [*3])
      else $error("status moved too early");
   AST_HG_ONCE: assert property (
      ctrl_write && wr_seen_q |=> $stable(high_gain_select))
      else $error("high gain rewritten");
   AST_REF_LOCK: assert property (
      ref_locked_q |-> !reference_select && !amp_enable)
      else $error("reference select not held low");
   AST_FALLBACK: assert property (
      actual_mode_status == 2'h3 && ref_lost
      |=> actual_mode_status == 2'h0 && mode_request_field == 2'h0)
      else $error("no fallback to self clocked");
   AST_LOCK_DROP: assert property (
      ctrl2_write && multiplier_in != multiplier_field |-> ##[1:2] !lock_q)
      else $error("lock kept over multiplier change");
endmodule
bind fll_clock_mode_generator clkgen_checker chk (.*);

// [tb/clkgen_partner.sv]
// source clocks and monitors around the clock mode generator
// assumes lock_ok from the bench stands for the loop lock state
module clkgen_partner (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic lock_ok,
   output logic      oscillator_clock,
   output logic      external_reference_clock,
   output logic      bus_clock,
   output logic      oscillator_stable_bit,
   output logic      external_reference_status,
   output logic      fll_lock_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int k_q;
   // periods 2, 5 and 3 cycles, all dividing 60
   always @(posedge clk) begin
      k_q                       <= (rst || k_q == 59) ? 0 : k_q + 1;
      oscillator_clock          <= !rst && k_q % 2 == 0;
      external_reference_clock  <= !rst && k_q % 5 == 0;
      bus_clock                 <= !rst && k_q % 3 == 0;
      oscillator_stable_bit     <= !rst;
      external_reference_status <= !rst;
      fll_lock_in               <= !rst && lock_ok;
   end
endmodule

// [tb/tb.sv]
// self-checking bench for the clock mode generator
// assumes partner sources: oscillator /2, reference /5, bus /3
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0, rst = 1'h1, ctrl_write = 1'h0, ctrl2_write = 1'h0;
   logic reference_select_in = 1'h0, range_in = 1'h0, high_gain_in = 1'h0;
   logic ref_lost = 1'h0, osc_lost = 1'h0, lock_ok = 1'h0;
   logic [1:0] mode_request_in = 2'h0, mode_request_field, actual_mode_status;
   logic [2:0] multiplier_in = 3'h0, divider_in = 3'h0, multiplier_field;
   logic [2:0] divider_field, m, d;
   logic [4:0] mult_n;
   logic [7:0] div_r, prescale_p;
   logic oscillator_clock, external_reference_clock, bus_clock, range_q;
   logic oscillator_stable_bit, external_reference_status, fll_lock_in;
   logic reference_select, amp_enable, high_gain_select, lock_q;
   logic loss_of_lock_flag, generator_output_clock, fixed_frequency_clock;
   logic fixed_clock_on, ref_used_for_output;
   logic [31:0] rng_q = 32'h6;
   int n_errors = 0, n_tests = 0, n_out, n_fix;
   logic [1:0] seq [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
   int eo [4] = '{120 / 4, 48 / 4, 120 / 4, 120 / 8};
   int ef [4] = '{0, 80, 0, 80};
   always #2 clk = ~clk;
   fll_clock_mode_generator dut (.*);
   clkgen_partner model (.*);
   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [7:0] exp_n(input logic [2:0] f);
      return 8'h4 + {4'h0, f, 1'h0};
   endfunction
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string what, input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'h1;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
   endtask
   task automatic wr1(input logic [1:0] md, input logic rs, rg, hg);
      @(posedge clk);
      ctrl_write <= 1'h1;
      mode_request_in <= md;
      reference_select_in <= rs;
      range_in <= rg;
      high_gain_in <= hg;
      @(posedge clk);
      ctrl_write <= 1'h0;
   endtask
   task automatic wr2(input logic [2:0] mf, df);
      @(posedge clk);
      ctrl2_write <= 1'h1;
      multiplier_in <= mf;
      divider_in <= df;
      @(posedge clk);
      ctrl2_write <= 1'h0;
   endtask
   task automatic count(input int n);
      n_out = 0;
      n_fix = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         n_out += (generator_output_clock === 1'h1);
         n_fix += (fixed_frequency_clock === 1'h1);
      end
   endtask
   task automatic pulse_loss(input logic which);
      @(posedge clk);
      if (which)
         osc_lost <= 1'h1;
      else
         ref_lost <= 1'h1;
      @(posedge clk);
      osc_lost <= 1'h0;
      ref_lost <= 1'h0;
      tick(1);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      #40000;
      n_errors++;
      wrap_up();
   end
   initial begin
      do_reset();
      wr1(2'h3, 1'h1, 1'h0, 1'h1);
      tick(1);
      chk("high_gain_select", high_gain_select, 8'h1);
      chk("reference_select", reference_select, 8'h1);
      wr1(2'h3, 1'h1, 1'h0, 1'h0);
      tick(1);
      chk("high_gain_select", high_gain_select, 8'h1);
      $display("test write_once done");
      for (int i = 0; i < 16; i++) begin
         rng_q = xorshift(rng_q);
         m = (i < 8) ? i[2:0] : rng_q[2:0];
         d = (i < 8) ? ~i[2:0] : rng_q[5:3];
         wr2(m, d);
         tick(2);
         chk("mult_n", mult_n, exp_n(m));
         chk("div_r", div_r, 8'h1 << d);
      end
      $display("test decode done");
      for (int i = 0; i < 2; i++) begin
         wr1(2'h3, 1'h1, i[0], 1'h0);
         tick(2);
         chk("prescale_p", prescale_p, i[0] ? 8'h01 : 8'h40);
      end
      wr2(3'h0, 3'h2);
      for (int i = 0; i < 4; i++) begin
         wr1(seq[i], 1'h1, 1'h0, 1'h0);
         tick(30);
         chk("actual_mode_status", actual_mode_status, seq[i]);
         chk("fixed_clock_on", fixed_clock_on, seq[i][1]);
         chk("ref_used_for_output", ref_used_for_output, seq[i][1]);
         count(240);
         chk("output pulses", n_out, eo[i]);
         chk("fixed pulses", n_fix, ef[i]);
      end
      lock_ok <= 1'h1;
      tick(30);
      count(240);
      chk("locked output pulses", n_out, 120 / 4);
      chk("locked fixed pulses", n_fix, 48 / 2);
      wr2(3'h1, 3'h2);
      wr1(2'h3, 1'h1, 1'h1, 1'h0);
      tick(30);
      count(240);
      chk("low ratio fixed pulses", n_fix, 80);
      chk("loss_of_lock_flag", loss_of_lock_flag, 8'h0);
      lock_ok <= 1'h0;
      tick(3);
      chk("loss_of_lock_flag", loss_of_lock_flag, 8'h1);
      $display("test modes done");
      pulse_loss(1'h0);
      chk("status after ref loss", actual_mode_status, 8'h0);
      chk("request after ref loss", mode_request_field, 8'h0);
      wr1(2'h3, 1'h1, 1'h1, 1'h0);
      tick(10);
      pulse_loss(1'h1);
      chk("status after osc loss", actual_mode_status, 8'h2);
      chk("request after osc loss", mode_request_field, 8'h2);
      $display("test fallback done");
      do_reset();
      wr1(2'h2, 1'h0, 1'h0, 1'h0);
      wr1(2'h2, 1'h1, 1'h0, 1'h1);
      tick(2);
      chk("reference_select", reference_select, 8'h0);
      chk("amp_enable", amp_enable, 8'h0);
      chk("high_gain_select", high_gain_select, 8'h0);
      $display("test reference lock done");
      wrap_up();
   end
endmodule
